// ==== src/ssf_pkg.sv ====
/*
  ssf_pkg: shared constants of the serial status flag block.
  Assumes a byte-wide register port with a 4-bit address.
*/
package ssf_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  ////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h1;
  localparam logic [3:0] OFS_TX_BUF  = 4'h2;
  localparam logic [3:0] OFS_RX_BUF  = 4'h3;

  ////////////////////////////////////////////////////////////
  // serial_status field positions
  localparam int unsigned ST_TX_BUFFER_EMPTY = 7;
  localparam int unsigned ST_RX_BUFFER_FULL = 6;
  localparam int unsigned ST_OVERRUN_ERROR = 5;
  localparam int unsigned ST_FER  = 4;
  localparam int unsigned ST_PER  = 3;
  localparam int unsigned ST_TX_END = 2;
  localparam int unsigned ST_MPB  = 1;
  localparam int unsigned ST_TX_MULTIPROC_BIT = 0;

  // serial_control field positions
  localparam int unsigned CT_TE     = 0;
  localparam int unsigned CT_RE     = 1;
  localparam int unsigned CT_SYNC   = 2;
  localparam int unsigned CT_PAR_EN = 3;
  localparam int unsigned CT_ODD    = 4;
  localparam int unsigned CT_MP     = 5;
  localparam logic [7:0]  CT_MASK   = 8'h3f;

  ////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] STATUS_RST  = 8'h84;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] BUF_RST     = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

endpackage

// ==== src/ssf_serial_status_flags.sv ====
/*
  ssf_serial_status_flags: status flags of one serial channel.
  Holds serial_status, a small serial_control, the transmit and
  receive buffers, and the clear-after-read protection of flags.
  Assumes shift engines that pulse on buffer take-over, on the
  last transmitted bit and on receive completion, handing over the
  first stop bit only, and a DMA port of one-cycle strobes.
*/
// Our own choices: the strobed register port and the register offsets.
//
// How it works
// - status is 8 bits, 0x84 after reset and on standby entry
// - writing 1 to a flag does nothing; 0 clears only after read as 1
// - writes to tx_end and rx_multiproc_bit ignored; bit 0 read/write
// - tx_buffer_empty sets when the shifter takes the tx buffer
// - tx_buffer_empty held 1 while transmitter disabled
// - dma write of tx buffer clears tx_buffer_empty
// - rx_buffer_full sets on error-free reception into rx buffer
// - dma read of rx buffer clears rx_buffer_full
// - errors and receiver disable keep rx_buffer_full; rx buffer kept except on framing or parity error
// - reception while rx_buffer_full sets overrun, new byte dropped
// - overrun halts reception; in sync mode also transmission
// - receiver disable leaves overrun and framing flags alone
// - async stop bit of 0 sets framing_error
// - with two stop bits only the first is checked
// - framing error loads rx buffer, rx_buffer_full stays clear
// - framing error halts reception; in sync mode transmission too
// - async parity mismatch against even or odd sets parity_error
// - framing errors only in asynchronous mode
// - parity error loads buffer without full flag, halts reception
// - tx_end sets on last bit with buffer empty, or tx disabled
// - tx_end clears on software tx_buffer_empty clear or dma write
`timescale 1ns/1ps

module ssf_serial_status_flags
  import ssf_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_standby,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  output logic      [DATA_W-1:0] o_rd_data,
  // dma port
  input  wire logic              i_dma_tx_wr,
  input  wire logic [7:0]        i_dma_tx_data,
  input  wire logic              i_dma_rx_rd,
  // transmit engine
  input  wire logic              i_tx_load,
  input  wire logic              i_tx_last_bit,
  output logic [7:0]             o_tx_buffer,
  output logic                   o_tx_buffer_empty,
  output logic                   o_tx_multiproc_bit,
  output logic                   o_tx_enable,
  // receive engine
  input  wire logic              i_rx_done,
  input  wire logic [7:0]        i_rx_data,
  input  wire logic              i_rx_stop_bit,
  input  wire logic              i_rx_parity_bit,
  input  wire logic              i_rx_mp_bit,
  output logic [7:0]             o_rx_buffer,
  output logic                   o_rx_enable,
  output logic [7:0]             o_serial_status,
  output logic [7:0]             o_serial_control
);

  logic [7:0] status_reg;
  logic [7:0] control_reg;
  logic [7:0] tx_buf_reg;
  logic [7:0] rx_buf_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] armed_reg;
  logic [7:0] armed_next;
  logic       rx_en_reg;
  logic       tx_en_reg;

  logic       sel_status;
  logic       sel_control;
  logic       sel_tx_buf;
  logic       sel_rx_buf;
  logic       st_wr;
  logic       st_rd;
  logic [7:0] clr_ok;

  logic       te;
  logic       re;
  logic       sync_mode;
  logic       any_err;
  logic       rx_take;
  logic       overrun;
  logic       frame_bad;
  logic       parity_bad;
  logic       rx_good;

  ////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    sel_status  = 1'b0;
    sel_control = 1'b0;
    sel_tx_buf  = 1'b0;
    sel_rx_buf  = 1'b0;
    if (i_addr == OFS_STATUS) begin
      sel_status = 1'b1;
    end else if (i_addr == OFS_CONTROL) begin
      sel_control = 1'b1;
    end else if (i_addr == OFS_TX_BUF) begin
      sel_tx_buf = 1'b1;
    end else if (i_addr == OFS_RX_BUF) begin
      sel_rx_buf = 1'b1;
    end
  end

  assign st_wr = i_wr_en & sel_status;
  assign st_rd = i_rd_en & sel_status;

  // a flag may be cleared only by a 0 written after it read as 1
  assign clr_ok = {8{st_wr}} & ~i_wr_data & armed_reg;

  ////////////////////////////////////////////////////////////
  // mode decode
  assign te        = control_reg[CT_TE];
  assign re        = control_reg[CT_RE];
  assign sync_mode = control_reg[CT_SYNC];
  assign any_err   = status_reg[ST_OVERRUN_ERROR] | status_reg[ST_FER]
                   | status_reg[ST_PER];

  // receive completion classification
  assign rx_take   = i_rx_done & rx_en_reg;
  assign overrun   = rx_take & status_reg[ST_RX_BUFFER_FULL];
  // only the first stop bit arrives, second is never looked at
  assign frame_bad = ~sync_mode & ~i_rx_stop_bit;
  assign parity_bad = ~sync_mode & control_reg[CT_PAR_EN]
                    & ((^i_rx_data) ^ i_rx_parity_bit
                       ^ control_reg[CT_ODD]);
  assign rx_good   = rx_take & ~overrun & ~frame_bad & ~parity_bad;

  ////////////////////////////////////////////////////////////
  // armed bits: set by a status read showing the flag as 1
  always_comb begin
    armed_next = armed_reg;
    if (st_wr) begin
      armed_next = 8'h00;
    end
    if (st_rd) begin
      armed_next = armed_next | status_reg;
    end
    // a flag that is already 0 carries no pending read
    armed_next = armed_next & status_reg;
    armed_next[ST_TX_END] = 1'b0;
    armed_next[ST_MPB]  = 1'b0;
    armed_next[ST_TX_MULTIPROC_BIT] = 1'b0;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      armed_reg <= 8'h00;
    end else if (i_standby) begin
      armed_reg <= 8'h00;
    end else begin
      armed_reg <= armed_next;
    end
  end

  ////////////////////////////////////////////////////////////
  // serial_control register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      control_reg <= CONTROL_RST;
    end else if (i_standby) begin
      control_reg <= CONTROL_RST;
    end else if (i_wr_en && sel_control) begin
      control_reg <= i_wr_data & CT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////
  // tx_buffer_empty flag
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_TX_BUFFER_EMPTY] <= STATUS_RST[ST_TX_BUFFER_EMPTY];
    end else if (i_standby) begin
      status_reg[ST_TX_BUFFER_EMPTY] <= STATUS_RST[ST_TX_BUFFER_EMPTY];
    end else if (!te) begin
      status_reg[ST_TX_BUFFER_EMPTY] <= 1'b1;
    end else if (i_tx_load) begin
      status_reg[ST_TX_BUFFER_EMPTY] <= 1'b1;
    end else if (i_dma_tx_wr) begin
      status_reg[ST_TX_BUFFER_EMPTY] <= 1'b0;
    end else if (clr_ok[ST_TX_BUFFER_EMPTY]) begin
      status_reg[ST_TX_BUFFER_EMPTY] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // tx_end flag, not writable
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_TX_END] <= STATUS_RST[ST_TX_END];
    end else if (i_standby) begin
      status_reg[ST_TX_END] <= STATUS_RST[ST_TX_END];
    end else if (!te) begin
      status_reg[ST_TX_END] <= 1'b1;
    end else if (i_tx_last_bit && status_reg[ST_TX_BUFFER_EMPTY]) begin
      status_reg[ST_TX_END] <= 1'b1;
    end else if (i_dma_tx_wr || clr_ok[ST_TX_BUFFER_EMPTY]) begin
      status_reg[ST_TX_END] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // rx_buffer_full flag; errors and receiver disable leave it
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_RX_BUFFER_FULL] <= STATUS_RST[ST_RX_BUFFER_FULL];
    end else if (i_standby) begin
      status_reg[ST_RX_BUFFER_FULL] <= STATUS_RST[ST_RX_BUFFER_FULL];
    end else if (rx_good) begin
      status_reg[ST_RX_BUFFER_FULL] <= 1'b1;
    end else if (i_dma_rx_rd) begin
      status_reg[ST_RX_BUFFER_FULL] <= 1'b0;
    end else if (clr_ok[ST_RX_BUFFER_FULL]) begin
      status_reg[ST_RX_BUFFER_FULL] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // overrun flag, set wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_OVERRUN_ERROR] <= STATUS_RST[ST_OVERRUN_ERROR];
    end else if (i_standby) begin
      status_reg[ST_OVERRUN_ERROR] <= STATUS_RST[ST_OVERRUN_ERROR];
    end else if (overrun) begin
      status_reg[ST_OVERRUN_ERROR] <= 1'b1;
    end else if (clr_ok[ST_OVERRUN_ERROR]) begin
      status_reg[ST_OVERRUN_ERROR] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // framing error flag
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_FER] <= STATUS_RST[ST_FER];
    end else if (i_standby) begin
      status_reg[ST_FER] <= STATUS_RST[ST_FER];
    end else if (rx_take && !overrun && frame_bad) begin
      status_reg[ST_FER] <= 1'b1;
    end else if (clr_ok[ST_FER]) begin
      status_reg[ST_FER] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // parity error flag
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_PER] <= STATUS_RST[ST_PER];
    end else if (i_standby) begin
      status_reg[ST_PER] <= STATUS_RST[ST_PER];
    end else if (rx_take && !overrun && parity_bad) begin
      status_reg[ST_PER] <= 1'b1;
    end else if (clr_ok[ST_PER]) begin
      status_reg[ST_PER] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // received multiprocessor bit, not writable
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_MPB] <= STATUS_RST[ST_MPB];
    end else if (i_standby) begin
      status_reg[ST_MPB] <= STATUS_RST[ST_MPB];
    end else if (rx_take && !overrun && !sync_mode
                 && control_reg[CT_MP]) begin
      status_reg[ST_MPB] <= i_rx_mp_bit;
    end
  end

  ////////////////////////////////////////////////////////////
  // transmit multiprocessor bit, plain read/write
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg[ST_TX_MULTIPROC_BIT] <= STATUS_RST[ST_TX_MULTIPROC_BIT];
    end else if (i_standby) begin
      status_reg[ST_TX_MULTIPROC_BIT] <= STATUS_RST[ST_TX_MULTIPROC_BIT];
    end else if (st_wr) begin
      status_reg[ST_TX_MULTIPROC_BIT] <= i_wr_data[ST_TX_MULTIPROC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////
  // transmit buffer, dma write takes precedence over cpu
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_buf_reg <= BUF_RST;
    end else if (i_dma_tx_wr) begin
      tx_buf_reg <= i_dma_tx_data;
    end else if (i_wr_en && sel_tx_buf) begin
      tx_buf_reg <= i_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////
  // receive buffer: loaded on error-free or flagged receptions,
  // kept on overrun so the older byte survives
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_buf_reg <= BUF_RST;
    end else if (rx_take && !overrun) begin
      rx_buf_reg <= i_rx_data;
    end
  end

  ////////////////////////////////////////////////////////////
  // engine enables, rx gated by pending receive errors, tx only in sync mode
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else if (i_standby) begin
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else begin
      rx_en_reg <= re & ~any_err;
      tx_en_reg <= te & ~(sync_mode & any_err);
    end
  end

  ////////////////////////////////////////////////////////////
  // read data, valid in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_reg <= UNMAPPED_RD;
    end else if (i_rd_en) begin
      if (sel_status) begin
        rd_data_reg <= status_reg;
      end else if (sel_control) begin
        rd_data_reg <= control_reg;
      end else if (sel_tx_buf) begin
        rd_data_reg <= tx_buf_reg;
      end else if (sel_rx_buf) begin
        rd_data_reg <= rx_buf_reg;
      end else begin
        rd_data_reg <= UNMAPPED_RD;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign o_rd_data          = rd_data_reg;
  assign o_tx_buffer        = tx_buf_reg;
  assign o_tx_buffer_empty  = status_reg[ST_TX_BUFFER_EMPTY];
  assign o_tx_multiproc_bit = status_reg[ST_TX_MULTIPROC_BIT];
  assign o_tx_enable        = tx_en_reg;
  assign o_rx_buffer        = rx_buf_reg;
  assign o_rx_enable        = rx_en_reg;
  assign o_serial_status    = status_reg;
  assign o_serial_control   = control_reg;

endmodule

// ==== verif/ssf_cpu_model.sv ====
/*
  ssf_cpu_model: cpu and dma side of the serial status block.
  Assumes one clock; strobes change just after a rising edge.
*/
`timescale 1ns/1ps

module ssf_cpu_model
  import ssf_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rd_data,
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wr_data,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic            o_dma_tx_wr,
  output logic            o_dma_rx_rd,
  output logic      [7:0] o_dma_data
);
  // idle bus at time zero
  initial begin
    {o_addr, o_wr_data, o_dma_data} = '0;
    {o_wr_en, o_rd_en, o_dma_tx_wr, o_dma_rx_rd} = '0;
  end

  ////////////////////////////////////////////////////////////
  // one-cycle write; released lines show inverted data
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    o_addr <= a;
    o_wr_data <= d;
    o_wr_en <= 1'b1;
    @(posedge i_clk_sys);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wr_data <= ~d;
    #1;
  endtask

  // one-cycle read; data stands in the next cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_clk_sys);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rd_data;
  endtask

  // dma buffer access: tx write or rx read
  task automatic dma(input logic tx, input logic [7:0] d);
    o_dma_data <= d;
    o_dma_tx_wr <= tx;
    o_dma_rx_rd <= !tx;
    @(posedge i_clk_sys);
    o_dma_tx_wr <= 1'b0;
    o_dma_rx_rd <= 1'b0;
    o_dma_data <= ~d;
    #1;
  endtask
endmodule

// ==== verif/ssf_serial_status_flags_assertions.sv ====
/*
  ssf_status_checker: port-level checks of the status flags.
  Assumes binding onto ssf_serial_status_flags by port name.
*/
`timescale 1ns/1ps

module ssf_status_checker
  import ssf_pkg::*;
(
  input wire logic i_clk_sys, i_resetn, i_standby,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en, i_rd_en, i_dma_tx_wr, i_dma_rx_rd,
  input wire logic [7:0] i_dma_tx_data, i_rx_data,
  input wire logic i_tx_load, i_tx_last_bit, i_rx_done,
  input wire logic i_rx_stop_bit, o_tx_enable, o_rx_enable,
  input logic [7:0] o_tx_buffer, o_rx_buffer,
  input logic [7:0] o_serial_status, o_serial_control
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire logic st_wr = i_wr_en && i_addr == OFS_STATUS;
  wire logic rx_go = o_rx_enable && i_rx_done && !i_standby;

  ////////////////////////////////////////////////////////////
  property p_standby;
    i_standby |=> o_serial_status == 8'h84;
  endproperty
  a_standby: assert property (p_standby)
    else $error("status not 0x84 after standby");
  property p_te_off;
    !o_serial_control[0] |=> o_serial_status[7] && o_serial_status[2];
  endproperty
  a_te_off: assert property (p_te_off)
    else $error("empty flags not held while tx disabled");
  property p_no_set;
    st_wr && !o_serial_status[6] && !i_rx_done |=> !o_serial_status[6];
  endproperty
  a_no_set: assert property (p_no_set)
    else $error("written one set a flag");
  property p_armed;
    i_rd_en && i_addr == OFS_STATUS && o_serial_status[5] ##1
      st_wr && !i_wr_data[5] && !i_rx_done |=> !o_serial_status[5];
  endproperty
  a_armed: assert property (p_armed)
    else $error("armed clear failed");
  property p_rx_good;
    rx_go && !o_serial_status[6] && i_rx_stop_bit &&
      !o_serial_control[3] |=>
      o_serial_status[6] && o_rx_buffer == $past(i_rx_data);
  endproperty
  a_rx_good: assert property (p_rx_good)
    else $error("good reception not stored");
  property p_overrun;
    rx_go && o_serial_status[6] |=>
      o_serial_status[5] && $stable(o_rx_buffer);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");
  property p_fer;
    rx_go && !o_serial_status[6] && !i_rx_stop_bit &&
      !o_serial_control[2] |=>
      o_serial_status[4] && !o_serial_status[6] ##1 !o_rx_enable;
  endproperty
  a_fer: assert property (p_fer)
    else $error("framing error handling wrong");
  property p_halt;
    |o_serial_status[5:3] |=> !o_rx_enable;
  endproperty
  a_halt: assert property (p_halt)
    else $error("reception not halted");
  property p_sync_tx;
    o_serial_control[2] && |o_serial_status[5:3] |=> !o_tx_enable;
  endproperty
  a_sync_tx: assert property (p_sync_tx)
    else $error("sync transmit not blocked");
  property p_dma_tx;
    i_dma_tx_wr && o_serial_control[0] && !i_tx_load && !i_wr_en &&
      !i_tx_last_bit && !i_standby |=>
      !o_serial_status[7] && !o_serial_status[2] &&
      o_tx_buffer == $past(i_dma_tx_data);
  endproperty
  a_dma_tx: assert property (p_dma_tx)
    else $error("dma write did not clear empty");
  property p_load;
    i_tx_load |=> o_serial_status[7];
  endproperty
  a_load: assert property (p_load)
    else $error("load did not set empty");
  property p_dma_rx;
    i_dma_rx_rd && !i_rx_done |=> !o_serial_status[6];
  endproperty
  a_dma_rx: assert property (p_dma_rx)
    else $error("dma read did not clear full");
  property p_ro_bits;
    st_wr && !i_rx_done && !i_standby |=>
      $stable(o_serial_status[1]) && o_serial_status[0] == $past(i_wr_data[0]);
  endproperty
  a_ro_bits: assert property (p_ro_bits)
    else $error("read-only or data bit write wrong");
  c_over: cover property (rx_go && o_serial_status[6]);
  c_fer: cover property (rx_go && !i_rx_stop_bit);
  c_stby: cover property (i_standby);
endmodule

// ==== verif/ssf_serial_status_flags_tb.sv ====
/*
  ssf_serial_status_flags_tb: directed scenarios for the status block.
  Assumes the cpu model as register and dma master; engines from here.
*/
`timescale 1ns/1ps

module ssf_serial_status_flags_tb;
  import ssf_pkg::*;
  logic clk = 0, resetn = 0, standby = 0, ld = 0, last = 0;
  logic rx_done = 0, stop = 0, par = 0, mp = 0;
  logic [7:0] rx_data = 0, d;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, dmad, txb, rxb, st, ctl;
  logic we, re, dtx, drx, txe, txmp, txen, rxen;
  int err_total = 0, num_checks = 0, cyc = 0;

  ssf_cpu_model cpu (.i_clk_sys(clk), .i_rd_data(rdata), .o_addr(addr),
    .o_wr_data(wdata), .o_wr_en(we), .o_rd_en(re), .o_dma_tx_wr(dtx),
    .o_dma_rx_rd(drx), .o_dma_data(dmad));
  ssf_serial_status_flags uut (.i_clk_sys(clk), .i_resetn(resetn),
    .i_standby(standby), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdata), .i_dma_tx_wr(dtx),
    .i_dma_tx_data(dmad), .i_dma_rx_rd(drx), .i_tx_load(ld),
    .i_tx_last_bit(last), .o_tx_buffer(txb), .o_tx_buffer_empty(txe),
    .o_tx_multiproc_bit(txmp), .o_tx_enable(txen), .i_rx_done(rx_done),
    .i_rx_data(rx_data), .i_rx_stop_bit(stop), .i_rx_parity_bit(par),
    .i_rx_mp_bit(mp), .o_rx_buffer(rxb), .o_rx_enable(rxen),
    .o_serial_status(st), .o_serial_control(ctl));

  // clock and hang limit
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // engine pulses: bit0 load, bit1 last bit
  task automatic eng(input logic [1:0] k);
    {last, ld} <= k;
    @(posedge clk);
    {last, ld} <= 2'b00;
    #1;
  endtask
  // one received character after an idle cycle
  task automatic rx(input logic [7:0] v, input logic s, p);
    @(posedge clk);
    rx_data <= v;
    stop <= s;
    par <= p;
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_data <= ~v;
    #1;
  endtask
  // read status then clear all flags
  task automatic clr();
    cpu.rd(OFS_STATUS, d);
    cpu.wr(OFS_STATUS, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    cpu.rd(OFS_STATUS, d); chk(d, 8'h84);
    cpu.rd(OFS_CONTROL, d); chk(d, 8'h00);
    cpu.rd(4'h9, d); chk(d, 8'h00);
  endtask
  task automatic t_tx();
    cpu.wr(OFS_CONTROL, 8'h03);
    cpu.dma(1'b1, 8'h5a); chk(st, 8'h00);
    chk(txb, 8'h5a);
    eng(2'b01); chk(st, 8'h80);
    eng(2'b10); chk(st, 8'h84);
    cpu.wr(OFS_STATUS, 8'h00); chk(st, 8'h84);
    cpu.rd(OFS_STATUS, d);
    cpu.wr(OFS_STATUS, 8'h01); chk(st, 8'h01);
    chk({7'h0, txmp}, 8'h01);
    cpu.wr(OFS_STATUS, 8'hfe); chk(st, 8'h00);
  endtask
  task automatic t_rx();
    rx(8'h3c, 1, 0); chk(st, 8'h40);
    chk(rxb, 8'h3c);
    rx(8'h11, 1, 0); chk(st, 8'h60);
    chk(rxb, 8'h3c);
    rx(8'h22, 1, 0); chk(rxb, 8'h3c);
    chk({7'h0, rxen}, 8'h00);
    cpu.dma(1'b0, 8'h00); chk(st, 8'h20);
    clr(); chk(st, 8'h00);
  endtask
  task automatic t_fer();
    rx(8'h77, 0, 0); chk(st, 8'h10);
    chk(rxb, 8'h77);
    cpu.wr(OFS_CONTROL, 8'h01); chk(st, 8'h10);
    clr();
    cpu.wr(OFS_CONTROL, 8'h07);
    rx(8'h12, 0, 0); chk(st, 8'h40);
    cpu.dma(1'b0, 8'h00);
  endtask
  task automatic t_par();
    cpu.wr(OFS_CONTROL, 8'h0b);
    rx(8'h01, 1, 0); chk(st, 8'h08);
    chk(rxb, 8'h01);
    clr();
    cpu.wr(OFS_CONTROL, 8'h1b);
    rx(8'h01, 1, 0); chk(st, 8'h40);
    cpu.dma(1'b0, 8'h00);
  endtask
  // sync mode overrun blocks transmit; multiproc bit capture
  task automatic t_sync();
    cpu.wr(OFS_CONTROL, 8'h07);
    rx(8'h41, 1, 0); chk({7'h0, txen}, 8'h01);
    rx(8'h42, 1, 0); chk(st, 8'h60);
    eng(2'b00); chk({7'h0, txen}, 8'h00);
    clr(); chk(st, 8'h00);
    eng(2'b00); chk({7'h0, txen}, 8'h01);
    cpu.wr(OFS_CONTROL, 8'h23);
    mp <= 1'b1;
    rx(8'h43, 1, 0); chk(st, 8'h42);
    cpu.wr(OFS_STATUS, 8'h00); chk(st, 8'h42);
    mp <= 1'b0;
    cpu.dma(1'b0, 8'h00); chk(st, 8'h02);
  endtask
  task automatic t_stby();
    cpu.wr(OFS_STATUS, 8'h01);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    #1 chk(st, 8'h84);
    chk(ctl, 8'h00);
    cpu.dma(1'b1, 8'h33); chk(st, 8'h84);
  endtask

  task complete_run();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_tx();
    t_rx();
    t_fer();
    t_par();
    t_sync();
    t_stby();
    complete_run();
  end
endmodule

bind ssf_serial_status_flags ssf_status_checker chk_i (.*);
